//--- core/fsc_cyc_if.sv
// Request and answer link between the controller sequencer and its bus cycle engine.
`timescale 1ns/1ps
`default_nettype none
interface fsc_cyc_if;
   logic req;          // One-cycle pulse that starts a bus cycle.
   logic is_write;     // High for a command write, low for a read.
   logic [7:0] code;   // Command code placed on the low data lines.
   logic addr0;        // Level for the identifier select address pin.
   logic done;         // One-cycle pulse when the cycle has fully ended.
   logic [15:0] rdata; // Data sampled at the end of a read strobe.
   modport seq (output req, output is_write, output code, output addr0, input done, input rdata);
   modport eng (input req, input is_write, input code, input addr0, output done, output rdata);
endinterface
`default_nettype wire

//--- core/fsc_cycle.sv
// Bus cycle engine: drives one asynchronous write or read cycle on the flash pins.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_defs.svh"
module fsc_cycle #(
   parameter int STROBE_CYC = `FSC_STROBE_CYC,
   parameter int RECOVER_CYC = `FSC_RECOVER_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   fsc_cyc_if.eng cyc,
   input wire logic word_mode,
   output logic chip_sel_n,
   output logic out_en_n,
   output logic write_en_n,
   output logic identifier_select_addr,
   input wire logic [15:0] dq_in,
   output logic [15:0] dq_out,
   output logic [15:0] dq_oe
);
   import fsc_pkg::*;
   // ----------------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------------
   // The 4-bit counter must hold the strobe plus the synchroniser delay.
   if (STROBE_CYC < 1 || STROBE_CYC + `FSC_SYNC_CYC > 15 || RECOVER_CYC < 1 || RECOVER_CYC > 15) begin : g_chk
      $error("fsc_cycle: timing counts out of range");
   end
   fsc_phase_type phase; // Current phase of the bus cycle.
   logic [3:0] cnt;      // Cycles left in the strobe or recovery phase.
   logic [15:0] dq_meta; // First synchroniser stage, read only by dq_sync.
   logic [15:0] dq_sync; // Data pins after two flip-flops.
   // Pin drive for the data lines: in byte mode line 15 is the half select, kept low for the low half.
   wire [15:0] wr_drive = word_mode ? {8'h00, cyc.code} : {8'h00, cyc.code};
   wire [15:0] wr_enable = word_mode ? 16'hffff : 16'h80ff;
   wire [15:0] rd_enable = word_mode ? 16'h0000 : 16'h8000;
   wire [3:0] strobe_len = 4'(STROBE_CYC - 1 + (cyc.is_write ? 0 : `FSC_SYNC_CYC));
   // ----------------------------------------------------------------------------
   // Input synchroniser
   // ----------------------------------------------------------------------------
   // The data pins come from outside the clock domain, so they pass two flops first.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dq_meta <= 16'h0000;
         dq_sync <= 16'h0000;
      end else begin
         dq_meta <= dq_in;
         dq_sync <= dq_meta;
      end
   end
   // ----------------------------------------------------------------------------
   // Cycle sequencer
   // ----------------------------------------------------------------------------
   // Chip select and the strobe both rise at the end of every cycle, so every read gets its own falling edge.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         phase <= FSC_PH_IDLE;
         cnt <= 4'h0;
         chip_sel_n <= 1'b1;
         out_en_n <= 1'b1;
         write_en_n <= 1'b1;
         identifier_select_addr <= 1'b0;
         dq_out <= 16'h0000;
         dq_oe <= 16'h0000;
         cyc.done <= 1'b0;
         cyc.rdata <= 16'h0000;
      end else begin
         cyc.done <= 1'b0;
         unique case (phase)
            FSC_PH_IDLE: begin
               if (cyc.req) begin
                  chip_sel_n <= 1'b0;
                  identifier_select_addr <= cyc.addr0;
                  dq_out <= cyc.is_write ? wr_drive : 16'h0000;
                  dq_oe <= cyc.is_write ? wr_enable : rd_enable;
                  phase <= FSC_PH_SETUP;
               end
            end
            FSC_PH_SETUP: begin
               write_en_n <= !cyc.is_write;
               out_en_n <= cyc.is_write;
               cnt <= strobe_len;
               phase <= FSC_PH_STROBE;
            end
            FSC_PH_STROBE: begin
               if (cnt == 4'h0) begin
                  // Read data is taken before the strobe lets go of the bus.
                  if (!cyc.is_write) begin
                     cyc.rdata <= dq_sync;
                  end
                  write_en_n <= 1'b1;
                  out_en_n <= 1'b1;
                  chip_sel_n <= 1'b1;
                  dq_oe <= rd_enable;
                  cnt <= 4'(RECOVER_CYC - 1);
                  phase <= FSC_PH_RECOVER;
               end else begin
                  cnt <= cnt - 4'h1;
               end
            end
            FSC_PH_RECOVER: begin
               if (cnt == 4'h0) begin
                  cyc.done <= 1'b1;
                  phase <= FSC_PH_IDLE;
               end else begin
                  cnt <= cnt - 4'h1;
               end
            end
         endcase
      end
   end
   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   sequence seq_released;
      out_en_n && chip_sel_n;
   endsequence
   property prop_read_toggles;
      @(posedge core_clk) disable iff (!rst_n) $rose(out_en_n) |-> seq_released [*2];
   endproperty
   AST_READ_TOGGLES: assert property (prop_read_toggles) else $error("read strobe not released between reads");
   AST_WRITE_WIDTH: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(write_en_n) |-> (!write_en_n && !chip_sel_n && dq_oe[0]) [*2] ##1 write_en_n)
      else $error("command write strobe has wrong width");
endmodule
`default_nettype wire

//--- core/fsc_defs.svh
// Constants of the flash status controller: offsets, command codes, field positions and timing counts.
`ifndef FSC_DEFS_SVH
`define FSC_DEFS_SVH
// ----------------------------------------------------------------------------
// Clock and pin timing
// ----------------------------------------------------------------------------
`define FSC_CLK_PERIOD_NS 50
`define FSC_STROBE_NS 100
`define FSC_RECOVER_NS 50
`define FSC_STROBE_CYC ((`FSC_STROBE_NS + `FSC_CLK_PERIOD_NS - 1) / `FSC_CLK_PERIOD_NS)
`define FSC_RECOVER_CYC ((`FSC_RECOVER_NS + `FSC_CLK_PERIOD_NS - 1) / `FSC_CLK_PERIOD_NS)
`define FSC_SYNC_CYC 2
// ----------------------------------------------------------------------------
// Register offsets of the controller
// ----------------------------------------------------------------------------
`define FSC_OFF_CTRL 8'h00
`define FSC_OFF_CMD 8'h04
`define FSC_OFF_POLL 8'h08
`define FSC_OFF_STATUS 8'h0c
`define FSC_OFF_IRQ_STATUS 8'h10
`define FSC_OFF_IRQ_MASK 8'h14
`define FSC_OFF_READ 8'h18
`define FSC_OFF_DATA 8'h1c
// ----------------------------------------------------------------------------
// Control fields, reset values, interrupt bits
// ----------------------------------------------------------------------------
`define FSC_CTRL_WORD_BIT 0
`define FSC_CTRL_RUN_BIT 1
`define FSC_CTRL_RESET 2'h1
`define FSC_IRQ_DONE_BIT 0
`define FSC_IRQ_FAULT_BIT 1
// ----------------------------------------------------------------------------
// Device command codes and status byte layout
// ----------------------------------------------------------------------------
`define FSC_CMD_READ_STATUS 8'h70
`define FSC_CMD_CLEAR_STATUS 8'h50
`define FSC_CMD_READ_ARRAY 8'hff
`define FSC_READY_BIT 7
`define FSC_SUSPEND_BIT 6
`define FSC_ERASE_FAIL_BIT 5
`define FSC_PROG_FAIL_BIT 4
`define FSC_SUPPLY_FAULT_BIT 3
`define FSC_STATUS_KEEP_MASK 8'hf8
`define FSC_FAULT_MASK 8'h38
`endif

//--- core/fsc_pkg.sv
// Types shared by the flash status controller modules.
package fsc_pkg;
   // Controller sequence states.
   typedef enum logic [2:0] {
      FSC_IDLE = 3'b000,
      FSC_CMD = 3'b001,
      FSC_POLL_CMD = 3'b010,
      FSC_POLL_READ = 3'b011,
      FSC_READ = 3'b100
   } fsc_state_type;
   // Phases of one bus cycle on the flash pins.
   typedef enum logic [1:0] {
      FSC_PH_IDLE = 2'b00,
      FSC_PH_SETUP = 2'b01,
      FSC_PH_STROBE = 2'b10,
      FSC_PH_RECOVER = 2'b11
   } fsc_phase_type;
endpackage

//--- core/fsc_top.sv
// Flash status controller: issues commands to the flash, polls its status byte, reports over a register port.
// Overview of operation
// - Write read-status command, read low status byte.
// - Toggle chip select or output enable per read.
// - Bit 7 ready; other bits invalid while busy.
// - Mask reserved status bits 2 to 0.
// - Send read-status code on low lines first.
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_defs.svh"
module fsc_top #(
   parameter int STROBE_CYC = `FSC_STROBE_CYC,
   parameter int RECOVER_CYC = `FSC_RECOVER_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq,
   output logic chip_sel_n,
   output logic out_en_n,
   output logic write_en_n,
   output logic reset_powerdown_n,
   output logic word_mode,
   output logic identifier_select_addr,
   input wire logic [15:0] dq_in,
   output logic [15:0] dq_out,
   output logic [15:0] dq_oe
);
   import fsc_pkg::*;
   // ----------------------------------------------------------------------------
   // State and registers
   // ----------------------------------------------------------------------------
   fsc_cyc_if cyc();
   fsc_state_type state;   // Sequencer state.
   logic [1:0] ctrl;       // Width select and powerdown release.
   logic [7:0] last_cmd;   // Last command code sent.
   logic [7:0] status;     // Last status byte, reserved bits masked.
   logic [15:0] data;      // Last data word read by a plain read.
   logic [1:0] irq_sts;    // Sticky events, write one to clear.
   logic [1:0] irq_mask;   // Enables for the interrupt output.
   logic req;              // Request pulse to the cycle engine.
   logic req_write;        // Kind of the requested cycle.
   logic [7:0] req_code;   // Code of the requested write.
   logic req_addr0;        // Identifier select level for the request.
   // ----------------------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------------------
   wire idle = (state == FSC_IDLE);
   wire wr_ctrl = reg_wr && reg_addr == `FSC_OFF_CTRL;
   wire wr_cmd = reg_wr && reg_addr == `FSC_OFF_CMD && idle;
   wire wr_poll = reg_wr && reg_addr == `FSC_OFF_POLL && idle && reg_wdata[0];
   wire wr_read = reg_wr && reg_addr == `FSC_OFF_READ && idle;
   wire wr_irq_sts = reg_wr && reg_addr == `FSC_OFF_IRQ_STATUS;
   wire wr_irq_mask = reg_wr && reg_addr == `FSC_OFF_IRQ_MASK;
   // Only the low byte carries status; reserved bits 2..0 are dropped.
   wire [7:0] status_new = cyc.rdata[7:0] & `FSC_STATUS_KEEP_MASK;
   wire poll_ans = (state == FSC_POLL_READ) && cyc.done;
   wire ready = status_new[`FSC_READY_BIT];
   // Fault bits count only once the ready bit is set.
   wire fault_evt = poll_ans && ready && |(status_new & `FSC_FAULT_MASK);
   wire [1:0] irq_set = {fault_evt, poll_ans && ready};
   wire [1:0] irq_clr = wr_irq_sts ? reg_wdata[1:0] : 2'b00;
   wire [31:0] rd_mux =
      reg_addr == `FSC_OFF_CTRL ? {30'h0, ctrl} :
      reg_addr == `FSC_OFF_CMD ? {24'h0, last_cmd} :
      reg_addr == `FSC_OFF_POLL ? {31'h0, !idle} :
      reg_addr == `FSC_OFF_STATUS ? {24'h0, status} :
      reg_addr == `FSC_OFF_IRQ_STATUS ? {30'h0, irq_sts} :
      reg_addr == `FSC_OFF_IRQ_MASK ? {30'h0, irq_mask} :
      reg_addr == `FSC_OFF_DATA ? {16'h0, data} : 32'h0000_0000;
   assign cyc.req = req;
   assign cyc.is_write = req_write;
   assign cyc.code = req_code;
   assign cyc.addr0 = req_addr0;
   assign reset_powerdown_n = ctrl[`FSC_CTRL_RUN_BIT];
   assign word_mode = ctrl[`FSC_CTRL_WORD_BIT];
   // ----------------------------------------------------------------------------
   // Register port and interrupt
   // ----------------------------------------------------------------------------
   // Read data stands one cycle after the strobe; the set of a sticky bit beats its clear.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctrl <= `FSC_CTRL_RESET;
         irq_mask <= 2'b00;
         irq_sts <= 2'b00;
         irq <= 1'b0;
         reg_rdata <= 32'h0000_0000;
      end else begin
         if (wr_ctrl) begin
            ctrl <= reg_wdata[1:0];
         end
         if (wr_irq_mask) begin
            irq_mask <= reg_wdata[1:0];
         end
         irq_sts <= (irq_sts & ~irq_clr) | irq_set;
         irq <= |(((irq_sts & ~irq_clr) | irq_set) & irq_mask);
         reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end
   // ----------------------------------------------------------------------------
   // Command and poll sequencer
   // ----------------------------------------------------------------------------
   // Requests while busy are ignored; software watches the busy bit of the poll register.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state <= FSC_IDLE;
         req <= 1'b0;
         req_write <= 1'b0;
         req_code <= `FSC_CMD_READ_ARRAY;
         req_addr0 <= 1'b0;
         last_cmd <= `FSC_CMD_READ_ARRAY;
         status <= 8'h00;
         data <= 16'h0000;
      end else begin
         req <= 1'b0;
         unique case (state)
            FSC_IDLE: begin
               if (wr_cmd) begin
                  req <= 1'b1;
                  req_write <= 1'b1;
                  req_code <= reg_wdata[7:0];
                  last_cmd <= reg_wdata[7:0];
                  state <= FSC_CMD;
               end else if (wr_poll) begin
                  // Status mode is entered freshly each poll, whatever mode the device was left in.
                  req <= 1'b1;
                  req_write <= 1'b1;
                  req_code <= `FSC_CMD_READ_STATUS;
                  last_cmd <= `FSC_CMD_READ_STATUS;
                  state <= FSC_POLL_CMD;
               end else if (wr_read) begin
                  req <= 1'b1;
                  req_write <= 1'b0;
                  req_addr0 <= reg_wdata[0];
                  state <= FSC_READ;
               end
            end
            FSC_CMD: begin
               if (cyc.done) begin
                  state <= FSC_IDLE;
               end
            end
            FSC_POLL_CMD: begin
               if (cyc.done) begin
                  req <= 1'b1;
                  req_write <= 1'b0;
                  state <= FSC_POLL_READ;
               end
            end
            FSC_POLL_READ: begin
               if (cyc.done) begin
                  status <= status_new;
                  // The device refreshes status only on a new strobe edge, so each retry is a full new read.
                  if (ready) begin
                     state <= FSC_IDLE;
                  end else begin
                     req <= 1'b1;
                  end
               end
            end
            FSC_READ: begin
               if (cyc.done) begin
                  data <= cyc.rdata;
                  state <= FSC_IDLE;
               end
            end
            default: begin
               state <= FSC_IDLE;
            end
         endcase
      end
   end
   // ----------------------------------------------------------------------------
   // Cycle engine
   // ----------------------------------------------------------------------------
   fsc_cycle #(.STROBE_CYC(STROBE_CYC), .RECOVER_CYC(RECOVER_CYC)) u_cycle (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .cyc(cyc.eng),
      .word_mode(word_mode),
      .chip_sel_n(chip_sel_n),
      .out_en_n(out_en_n),
      .write_en_n(write_en_n),
      .identifier_select_addr(identifier_select_addr),
      .dq_in(dq_in),
      .dq_out(dq_out),
      .dq_oe(dq_oe)
   );
   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   // A plain command write of the same code is not a poll, so the poll state is part of the start.
   sequence seq_status_cmd;
      req && req_write && req_code == `FSC_CMD_READ_STATUS && state == FSC_POLL_CMD;
   endsequence
   AST_POLL_CODE: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state == FSC_POLL_CMD && $past(state) == FSC_IDLE) |-> req && req_write && req_code == `FSC_CMD_READ_STATUS)
      else $error("poll did not start with the read-status code");
   AST_POLL_ORDER: assert property (@(posedge core_clk) disable iff (!rst_n)
      seq_status_cmd |=> state == FSC_POLL_CMD ##[1:20] (req && !req_write && state == FSC_POLL_READ))
      else $error("status read did not follow the read-status write");
   AST_STATUS_LOW_BYTE: assert property (@(posedge core_clk) disable iff (!rst_n)
      poll_ans |=> status == ($past(cyc.rdata[7:0]) & 8'hf8))
      else $error("status not taken from the low data byte");
   AST_RESERVED_MASKED: assert property (@(posedge core_clk) disable iff (!rst_n)
      status[2:0] == 3'b000)
      else $error("reserved status bits not masked");
   AST_BUSY_REPOLLS: assert property (@(posedge core_clk) disable iff (!rst_n)
      (poll_ans && !cyc.rdata[7]) |-> !fault_evt ##1 (req && state == FSC_POLL_READ))
      else $error("busy status not polled again or fault taken while busy");
   AST_IRQ_LEVEL: assert property (@(posedge core_clk) disable iff (!rst_n)
      (fault_evt && irq_mask[1]) |=> (irq && irq_sts[1]))
      else $error("fault event did not raise the interrupt");
endmodule
`default_nettype wire

//--- verification/fsc_flash_model.sv
// Behavioural flash device that answers the status controller on its pins.
`timescale 1ns/1ps
`default_nettype none
module fsc_flash_model #(
   parameter logic [15:0] ARRAY_WORD = 16'h3c5a,
   parameter logic [15:0] MFR_CODE = 16'h0011, // Arbitrary value.
   parameter logic [15:0] DEV_CODE = 16'h0022 // Arbitrary value.
) (
   input wire logic core_clk,
   input wire logic chip_sel_n,
   input wire logic out_en_n,
   input wire logic write_en_n,
   input wire logic reset_powerdown_n,
   input wire logic word_mode,
   input wire logic identifier_select_addr,
   input wire logic [15:0] dq_out,
   input wire logic [15:0] dq_oe,
   input wire logic [7:0] busy_reads,
   input wire logic [2:0] fault_set,
   output logic [15:0] dq_in
);
   logic [7:0] mode_q = 8'hff; // Command mode in force.
   logic [7:0] status_q = 8'h00; // Status byte held for the whole read.
   logic [7:0] busy_left = 8'h00; // Busy answers still to give.
   logic [2:0] fault_q = 3'h0; // Sticky fault bits.
   logic suspend_q = 1'b0;
   logic rd_q = 1'b0;
   logic wr_q = 1'b0;
   logic [15:0] wr_val = 16'h0000;
   logic [15:0] float_pat = 16'h5aa5; // Released lines change every cycle, so a stale value never passes.
   // ----------------------------------------------------------------------------
   // Pin decode and read data
   // ----------------------------------------------------------------------------
   wire rd_act = reset_powerdown_n & ~chip_sel_n & ~out_en_n & write_en_n;
   wire wr_act = reset_powerdown_n & ~chip_sel_n & ~write_en_n & out_en_n;
   wire is_stat = (mode_q == 8'h70);
   wire half = dq_oe[15] ? dq_out[15] : float_pat[15];
   wire [15:0] id_word = identifier_select_addr ? DEV_CODE : MFR_CODE;
   wire [15:0] word_data = is_stat ? {8'h00, status_q} : (mode_q == 8'h90) ? id_word : ARRAY_WORD;
   wire [7:0] byte_data = (half & ~is_stat) ? word_data[15:8] : word_data[7:0];
   wire [15:0] dev_mask = rd_act ? (word_mode ? 16'hffff : 16'h00ff) : 16'h0000;
   wire [15:0] dev_val = word_mode ? word_data : {8'h00, byte_data};
   assign dq_in = (dq_oe & dq_out) | (~dq_oe & dev_mask & dev_val) | (~dq_oe & ~dev_mask & float_pat);
   // Commands end on the close of a write strobe; status latches on the strobe that opens a read.
   always @(posedge core_clk) begin
      float_pat <= ~float_pat;
      rd_q <= rd_act;
      wr_q <= wr_act;
      if (wr_act) begin
         wr_val <= dq_in;
      end
      if (!reset_powerdown_n) begin
         mode_q <= 8'hff;
         fault_q <= 3'h0;
         suspend_q <= 1'b0;
      end else if (wr_q && !wr_act) begin
         mode_q <= (wr_val[7:0] == 8'h50) ? 8'hff : wr_val[7:0];
         if (wr_val[7:0] == 8'h70) begin
            busy_left <= busy_reads;
         end
         if (wr_val[7:0] == 8'h50) begin
            fault_q <= 3'h0;
         end
         if (wr_val[7:0] == 8'hb0) begin
            suspend_q <= 1'b1;
         end
         if (wr_val[7:0] == 8'hd0) begin
            suspend_q <= 1'b0;
         end
      end else if (rd_act && !rd_q && is_stat) begin
         // Busy answers carry junk in the other bits, which the controller must ignore.
         if (busy_left != 8'h00) begin
            status_q <= 8'h25;
            busy_left <= busy_left - 8'h01;
         end else begin
            status_q <= {1'b1, suspend_q, fault_q | fault_set, 3'b101};
            fault_q <= fault_q | fault_set;
         end
      end
   end
endmodule
`default_nettype wire

//--- verification/fsc_top_tb_top.sv
// Self-checking bench of the flash status controller against the device model.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_defs.svh"
module fsc_top_tb_top;
   import fsc_pkg::*;
   logic core_clk, rst_n, reg_wr, reg_rd, irq, chip_sel_n, out_en_n, write_en_n, reset_powerdown_n, word_mode, id_addr;
   logic [7:0] reg_addr, busy_reads;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [15:0] dq_in, dq_out, dq_oe;
   logic [2:0] fault_set;
   int failures, n_compared;
   fsc_top fsc_top_i (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .chip_sel_n(chip_sel_n),
      .out_en_n(out_en_n), .write_en_n(write_en_n), .reset_powerdown_n(reset_powerdown_n),
      .word_mode(word_mode), .identifier_select_addr(id_addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
   fsc_flash_model fsc_flash_model_i (.core_clk(core_clk), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
      .write_en_n(write_en_n), .reset_powerdown_n(reset_powerdown_n), .word_mode(word_mode),
      .identifier_select_addr(id_addr), .dq_out(dq_out), .dq_oe(dq_oe), .busy_reads(busy_reads),
      .fault_set(fault_set), .dq_in(dq_in));
   // ----------------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so they are taken mid-cycle there.
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
   endtask
   // Bounded wait on the busy bit; a hang shows as a mismatch.
   task automatic wait_idle;
      repeat (3) @(posedge core_clk);
      for (int i = 0; i < 400; i++) begin
         rd(`FSC_OFF_POLL);
         if (d[0] === 1'b0) break;
      end
      check(d & 32'h1, 32'h0);
   endtask
   task automatic cmd(input logic [7:0] c);
      wr(`FSC_OFF_CMD, {24'h0, c});
      wait_idle();
   endtask
   task automatic poll(input logic [7:0] b, input logic [2:0] f);
      busy_reads <= b;
      fault_set <= f;
      wr(`FSC_OFF_POLL, 32'h1);
      wait_idle();
      rd(`FSC_OFF_STATUS);
   endtask
   task automatic rd_word(input logic a);
      wr(`FSC_OFF_READ, {31'h0, a});
      wait_idle();
      rd(`FSC_OFF_DATA);
   endtask
   // ----------------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------------
   task automatic t_reset;
      check({reset_powerdown_n, word_mode, chip_sel_n, irq}, 32'h6);
      check(dq_oe, 32'h0);
      rd(`FSC_OFF_CTRL);
      check(d, 32'h1);
      rd(`FSC_OFF_CMD);
      check(d, 32'hff);
      rd(8'h20);
      check(d, 32'h0);
   endtask
   task automatic t_poll_irq;
      wr(`FSC_OFF_CTRL, 32'h3);
      poll(8'd3, 3'h0);
      check(d, 32'h80);
      rd(`FSC_OFF_IRQ_STATUS);
      check(d, 32'h1);
      check(irq, 32'h0);
      wr(`FSC_OFF_IRQ_MASK, 32'h3);
      repeat (3) @(posedge core_clk);
      check(irq, 32'h1);
      wr(`FSC_OFF_IRQ_STATUS, 32'h1);
      repeat (3) @(posedge core_clk);
      check(irq, 32'h0);
   endtask
   task automatic t_faults;
      for (int i = 0; i < 3; i++) begin
         poll(8'd2, 3'h1 << i);
         check(d, 32'h80 | (32'h8 << i));
         rd(`FSC_OFF_IRQ_STATUS);
         check(d & 32'h2, 32'h2);
         wr(`FSC_OFF_IRQ_STATUS, 32'h3);
         cmd(8'h50);
         poll(8'd0, 3'h0);
         check(d, 32'h80);
      end
   endtask
   task automatic t_suspend;
      cmd(8'hb0);
      poll(8'd0, 3'h0);
      check(d, 32'hc0);
      cmd(8'hd0);
      poll(8'd1, 3'h0);
      check(d, 32'h80);
   endtask
   task automatic t_reads;
      cmd(8'hff);
      rd_word(1'b0);
      check(d, 32'h3c5a);
      cmd(8'h90);
      rd_word(1'b0);
      check(d, 32'h0011);
      rd_word(1'b1);
      check(d, 32'h0022);
      // The 0x70 write reloads the model with busy_reads, still one from the last poll, so the first strobe shows a busy answer.
      cmd(8'h70);
      rd_word(1'b0);
      check(d, 32'h0025);
      rd_word(1'b1);
      check(d, 32'h0085);
   endtask
   task automatic t_byte;
      wr(`FSC_OFF_CTRL, 32'h2);
      cmd(8'hff);
      check(word_mode, 32'h0);
      rd_word(1'b0);
      check(d & 32'hff, 32'h5a);
      poll(8'd1, 3'h0);
      check(d, 32'h80);
      wr(`FSC_OFF_CTRL, 32'h0);
      repeat (2) @(posedge core_clk);
      check(reset_powerdown_n, 32'h0);
   endtask
   task automatic finish_test;
      if (failures == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------------------
   // Clock, main sequence and watchdog
   // ----------------------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, busy_reads, fault_set} = '0;
      failures = 0;
      n_compared = 0;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      t_poll_irq();
      t_faults();
      t_suspend();
      t_reads();
      t_byte();
      finish_test();
   end
   // The whole run needs under a thousand cycles; this cuts a hang at 40000.
   initial begin
      #2000000;
      failures++;
      finish_test();
   end
endmodule
`default_nettype wire
